/* File: scd_pkg.sv */
// constants and carrier types for the secure configuration decryptor
package scd_pkg;
    localparam int KEY_W = 128;
    localparam int BLK_BYTES = 16;
    localparam int AES_ROUNDS = 10;
    localparam int SYNC_W = 16;
    localparam int CFG_BLOCKS = 4;
    localparam logic [7:0] HDR_ENC = 8'hA5;
    localparam logic [7:0] HDR_PLAIN = 8'h5A;
    // arbitrary check word expected in the first decrypted block
    localparam logic [31:0] CHECK_WORD = 32'hC0DEC0DE;
    localparam logic [79:0] RCON_TABLE = 80'h01020408102040801B36;
    localparam logic [7:0] SBOX_C = 8'h63;
    localparam logic [7:0] INV_SBOX_C = 8'h05;
    // pin bundle bit positions after synchronisation
    localparam int PIN_DCLK = 15;
    localparam int PIN_TCK = 14;
    localparam int PIN_TDI = 13;
    localparam int PIN_KEN = 12;
    localparam int PIN_HOLDN = 11;
    localparam int PIN_MODE = 8;
    localparam int PIN_DATA = 0;

    typedef enum logic [2:0] {
        MODE_FAST_PARALLEL_HOST = 3'h0,
        MODE_FAST_PARALLEL_MEM = 3'h1,
        MODE_ACTIVE_SERIAL = 3'h2,
        MODE_PASSIVE_SERIAL = 3'h3,
        MODE_ASYNC_PARALLEL = 3'h4,
        MODE_JTAG = 3'h5
    } scd_mode_type;

    typedef struct packed {
        logic keyed;
        logic busy;
        logic cfgFail;
        logic userMode;
    } scd_status_type;

    typedef struct packed {
        logic valid;
        logic [127:0] data;
    } scd_cell_type;
endpackage : scd_pkg

/* File: scd_config_decrypt.sv */
// secure configuration loader: otp key, aes-128 decryptor, bypass path
// Functional notes
// - one 128-bit key decrypts incoming configuration
// - key fuse written once, never altered; porRst clears it here and allows a new burn
// - keyed device accepts only same-key bitstreams
// - plain or wrong-key stream fails configuration
// - unused security routes data around decryptor
// - aes-128 inverse cipher on 128-bit blocks
// - no readback path for loaded configuration
// - decrypt in fast parallel host, active, passive serial
// - no decrypt for memory, async parallel, jtag
`timescale 1ns/1ps
`default_nettype none
module scd_config_decrypt (
    input wire logic clk,
    input wire logic rst,
    input wire logic porRst,
    input wire logic ce,
    input wire logic dataClk,
    input wire logic [7:0] dataIn,
    input wire logic [2:0] loadMode,
    input wire logic configuration_hold_n,
    input wire logic keyProgTck,
    input wire logic keyProgTdi,
    input wire logic keyProgEnable,
    output scd_pkg::scd_cell_type cellOut,
    output scd_pkg::scd_status_type status
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_KEYX = 7'h02, S_LOAD = 7'h04, S_DEC = 7'h08,
        S_EMIT = 7'h10, S_DONE = 7'h20, S_FAIL = 7'h40
    } scd_state_type;
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p, x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i]) p = p ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
        end
        return p;
    endfunction : gmul
    // x^254 is the field inverse; small area traded for deep logic
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 7; i >= 0; i--)
        begin
            r = gmul(r, r);
            if (i != 0) r = gmul(r, a);
        end
        return r;
    endfunction : ginv
    function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
        logic [15:0] d;
        d = {a, a} << n;
        return d[15:8];
    endfunction : rotl
    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] v;
        v = ginv(a);
        return v ^ rotl(v, 1) ^ rotl(v, 2) ^ rotl(v, 3) ^ rotl(v, 4) ^ scd_pkg::SBOX_C;
    endfunction : sbox
    function automatic logic [7:0] invSbox(input logic [7:0] a);
        return ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ scd_pkg::INV_SBOX_C);
    endfunction : invSbox
    function automatic logic [31:0] subRot(input logic [31:0] w, input logic [3:0] r);
        logic [7:0] rc;
        rc = scd_pkg::RCON_TABLE[8 * (10 - int'(r)) +: 8];
        return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
    endfunction : subRot
    function automatic logic [127:0] keyStep(input logic [127:0] k, input logic [3:0] r);
        logic [31:0] w0, w1, w2;
        w0 = k[127:96] ^ subRot(k[31:0], r);
        w1 = k[95:64] ^ w0;
        w2 = k[63:32] ^ w1;
        return {w0, w1, w2, k[31:0] ^ w2};
    endfunction : keyStep
    function automatic logic [127:0] invKeyStep(input logic [127:0] k, input logic [3:0] r);
        logic [31:0] p3;
        p3 = k[31:0] ^ k[63:32];
        return {k[127:96] ^ subRot(p3, r), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
    endfunction : invKeyStep
    // one inverse round; byte i of the block is column i/4, row i%4
    function automatic logic [127:0] invRound(input logic [127:0] s, input logic [127:0] k,
                                              input logic last);
        logic [127:0] t;
        logic [7:0] a0, a1, a2, a3;
        t = '0;
        for (int i = 0; i < 16; i++)
            t[127 - 8 * i -: 8] = invSbox(s[127 - 8 * (((i / 4 + 4 - i % 4) % 4) * 4 + i % 4) -: 8]);
        t = t ^ k;
        if (!last)
        begin
            for (int c = 0; c < 4; c++)
            begin
                {a0, a1, a2, a3} = t[127 - 32 * c -: 32];
                t[127 - 32 * c -: 32] = {
                    gmul(a0, 8'h0E) ^ gmul(a1, 8'h0B) ^ gmul(a2, 8'h0D) ^ gmul(a3, 8'h09),
                    gmul(a0, 8'h09) ^ gmul(a1, 8'h0E) ^ gmul(a2, 8'h0B) ^ gmul(a3, 8'h0D),
                    gmul(a0, 8'h0D) ^ gmul(a1, 8'h09) ^ gmul(a2, 8'h0E) ^ gmul(a3, 8'h0B),
                    gmul(a0, 8'h0B) ^ gmul(a1, 8'h0D) ^ gmul(a2, 8'h09) ^ gmul(a3, 8'h0E)};
            end
        end
        return t;
    endfunction : invRound
    // pins: three stages, a level counts once stages two and three agree
    logic [15:0] sync1, sync2, sync3, pinLvl, pinPrev;
    wire [15:0] pinRaw = {dataClk, keyProgTck, keyProgTdi, keyProgEnable,
                          configuration_hold_n, loadMode, dataIn};
    wire [15:0] pinAgree = ~(sync2 ^ sync3);
    wire [15:0] next_pinLvl = (sync2 & pinAgree) | (pinLvl & ~pinAgree);
    wire byteRise = pinLvl[scd_pkg::PIN_DCLK] & ~pinPrev[scd_pkg::PIN_DCLK];
    wire tckRise = pinLvl[scd_pkg::PIN_TCK] & ~pinPrev[scd_pkg::PIN_TCK];
    wire kenFall = ~pinLvl[scd_pkg::PIN_KEN] & pinPrev[scd_pkg::PIN_KEN];
    wire holdN = pinLvl[scd_pkg::PIN_HOLDN];
    wire [7:0] byteIn = pinLvl[scd_pkg::PIN_DATA +: 8];
    wire [2:0] modeIn = pinLvl[scd_pkg::PIN_MODE +: 3];
    // otp key: cleared only at power-on, never touched by rst
    logic [127:0] fuseKey, keyShift;
    logic fuseBlown;
    logic [7:0] keyBits;
    wire burn = kenFall && keyBits == 8'(scd_pkg::KEY_W) && !fuseBlown;
    always_ff @(posedge clk)
    begin
        if (porRst)
        begin
            fuseKey <= '0;
            fuseBlown <= 1'b0;
        end
        else if (ce && burn)
        begin
            fuseKey <= keyShift;
            fuseBlown <= 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            {sync1, sync2, sync3, pinLvl, pinPrev} <= '0;
            keyShift <= '0;
            keyBits <= 8'h00;
        end
        else if (ce)
        begin
            sync1 <= pinRaw;
            sync2 <= sync1;
            sync3 <= sync2;
            pinLvl <= next_pinLvl;
            pinPrev <= pinLvl;
            if (!pinLvl[scd_pkg::PIN_KEN])
                keyBits <= 8'h00;
            else if (tckRise)
            begin
                keyShift <= {keyShift[126:0], pinLvl[scd_pkg::PIN_TDI]};
                keyBits <= (keyBits == 8'(scd_pkg::KEY_W)) ? keyBits : keyBits + 8'h01;
            end
        end
    end
    scd_state_type state, next_state;
    logic [127:0] blk, aesState, roundKey, lastKey;
    logic [3:0] rnd, byteCnt;
    logic [7:0] blkCnt;
    logic hdrSeen, encMode, firstBlk;
    wire modeOk = modeIn inside {scd_pkg::MODE_FAST_PARALLEL_HOST, scd_pkg::MODE_ACTIVE_SERIAL,
                                 scd_pkg::MODE_PASSIVE_SERIAL};
    wire isEnc = byteIn == scd_pkg::HDR_ENC;
    wire isPlain = byteIn == scd_pkg::HDR_PLAIN;
    // keyed: only encrypted and a capable mode; unkeyed: only plain
    wire hdrBad = fuseBlown ? (!isEnc || !modeOk) : !isPlain;
    wire checkBad = encMode && firstBlk && blk[127:96] != scd_pkg::CHECK_WORD;
    wire lastBlk = blkCnt == 8'(scd_pkg::CFG_BLOCKS - 1);
    wire [127:0] prevKey = invKeyStep(roundKey, rnd);
    wire [127:0] decNext = invRound(aesState, prevKey, rnd == 4'h1);
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE: if (holdN) next_state = fuseBlown ? S_KEYX : S_LOAD;
            S_KEYX: if (rnd == 4'(scd_pkg::AES_ROUNDS)) next_state = S_LOAD;
            S_LOAD:
                if (byteRise && !hdrSeen && hdrBad) next_state = S_FAIL;
                else if (byteRise && hdrSeen && byteCnt == 4'hF)
                    next_state = encMode ? S_DEC : S_EMIT;
            S_DEC: if (rnd == 4'h1) next_state = S_EMIT;
            S_EMIT: next_state = checkBad ? S_FAIL : (lastBlk ? S_DONE : S_LOAD);
            S_DONE: next_state = S_DONE;
            S_FAIL: next_state = S_FAIL;
            default: next_state = S_IDLE;
        endcase
        if (!holdN) next_state = S_IDLE;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            {blk, aesState, roundKey, lastKey} <= '0;
            {rnd, byteCnt, blkCnt, hdrSeen, encMode, firstBlk} <= '0;
            cellOut <= '0;
            status <= '0;
        end
        else if (ce)
        begin
            state <= next_state;
            cellOut.valid <= 1'b0;
            status.keyed <= fuseBlown;
            status.busy <= !(state inside {S_IDLE, S_DONE, S_FAIL});
            status.userMode <= next_state == S_DONE;
            status.cfgFail <= next_state == S_FAIL;
            case (state)
                S_IDLE:
                begin
                    {rnd, byteCnt, blkCnt, hdrSeen, encMode} <= '0;
                    firstBlk <= 1'b1;
                    roundKey <= fuseKey;
                end
                S_KEYX:
                    if (rnd != 4'(scd_pkg::AES_ROUNDS))
                    begin
                        roundKey <= keyStep(roundKey, rnd + 4'h1);
                        rnd <= rnd + 4'h1;
                    end
                    else
                        lastKey <= roundKey;
                S_LOAD:
                    if (byteRise && !hdrSeen)
                    begin
                        hdrSeen <= 1'b1;
                        encMode <= isEnc;
                    end
                    else if (byteRise)
                    begin
                        blk <= {blk[119:0], byteIn};
                        byteCnt <= byteCnt + 4'h1;
                        aesState <= {blk[119:0], byteIn} ^ lastKey;
                        roundKey <= lastKey;
                        rnd <= 4'(scd_pkg::AES_ROUNDS);
                    end
                S_DEC:
                begin
                    aesState <= decNext;
                    roundKey <= prevKey;
                    rnd <= rnd - 4'h1;
                    if (rnd == 4'h1) blk <= decNext;
                end
                S_EMIT:
                begin
                    // only a write port into the cells exists; nothing reads them back
                    cellOut.valid <= !checkBad;
                    cellOut.data <= blk;
                    blkCnt <= blkCnt + 8'h01;
                    firstBlk <= 1'b0;
                end
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || porRst);
    // a low hold input aborts to idle, so the run only counts while it stays high
    sequence decRun_s;
        state == S_DEC && rnd == 4'hA && ce && holdN ##1 (ce && holdN)[*8] ##1 ce && holdN;
    endsequence
    sequence emitBad_s;
        state == S_EMIT && ce && checkBad && holdN;
    endsequence
    fuse_stays_a: assert property (fuseBlown && !porRst |=> $stable(fuseKey))
        else $error("fuse key changed after it was written");
    fuse_write_a: assert property (ce && burn |=> fuseBlown && fuseKey == $past(keyShift))
        else $error("fuse did not take the shifted key");
    keyed_plain_a: assert property (state == S_LOAD && ce && byteRise && !hdrSeen
                                    && fuseBlown && holdN && !isEnc |=> state == S_FAIL)
        else $error("keyed device took an unencrypted stream");
    mode_block_a: assert property (state == S_LOAD && ce && byteRise && !hdrSeen
                                   && fuseBlown && holdN && !modeOk |=> state == S_FAIL)
        else $error("decrypt accepted in an unsupported mode");
    wrong_key_a: assert property (emitBad_s |=> state == S_FAIL ##1 status.cfgFail)
        else $error("check word mismatch did not fail");
    bypass_data_a: assert property (state == S_EMIT && ce && !encMode
                                    |=> cellOut.valid && cellOut.data == $past(blk))
        else $error("bypass altered configuration data");
    dec_latency_a: assert property (decRun_s |=> state == S_EMIT)
        else $error("decryption did not finish in ten rounds");
    fail_status_a: assert property (state == S_FAIL && ce && holdN
                                    |=> status.cfgFail && !status.userMode && !cellOut.valid)
        else $error("failure did not block user mode");
    last_key_a: assert property (state != S_KEYX |=> $stable(lastKey))
        else $error("decrypt key changed outside expansion");
endmodule : scd_config_decrypt
`default_nettype wire

/* File: scd_host_model.sv */
// configuration host and key programmer model driving the loader pins
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
    input wire logic clk,
    output logic dataClk,
    output logic [7:0] dataIn,
    output logic [2:0] loadMode,
    output logic configuration_hold_n,
    output logic keyProgTck,
    output logic keyProgTdi,
    output logic keyProgEnable,
    output logic prog_voltage_select_n
);
    // half of the 80 ns link period, in 10 ns clock cycles
    localparam int HALF = 4;
    // stands in for the supply settle wait, scaled so the run stays short
    localparam int SETTLE = 100;

    initial
    begin
        dataClk = 1'b0;
        dataIn = 8'h00;
        loadMode = 3'h3;
        configuration_hold_n = 1'b0;
        keyProgTck = 1'b0;
        keyProgTdi = 1'b0;
        keyProgEnable = 1'b0;
        prog_voltage_select_n = 1'b1;
    end

    task wait_low(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_low

    task send_byte(input logic [7:0] b);
        // stale data in the low half must not look valid
        dataIn = ~b;
        wait_low(1);
        dataIn = b;
        wait_low(HALF);
        dataClk = 1'b1;
        wait_low(HALF);
        dataClk = 1'b0;
    endtask : send_byte

    task send_block(input logic [127:0] blk);
        int i;
        for (i = 0; i < 16; i++)
        begin
            send_byte(blk[127 - 8 * i -: 8]);
        end
        // bytes during decryption are lost, so leave room
        wait_low(15);
    endtask : send_block

    task prog_key(input logic [127:0] key, input int nBits);
        int i;
        configuration_hold_n = 1'b0;
        prog_voltage_select_n = 1'b0;
        wait_low(SETTLE);
        keyProgEnable = 1'b1;
        for (i = 0; i < nBits; i++)
        begin
            keyProgTdi = key[127 - i];
            wait_low(HALF);
            keyProgTck = 1'b1;
            wait_low(HALF);
            keyProgTck = 1'b0;
        end
        keyProgTdi = ~keyProgTdi;
        wait_low(HALF);
        keyProgEnable = 1'b0;
        wait_low(12);
        prog_voltage_select_n = 1'b1;
    endtask : prog_key

    task start_session(input logic [2:0] mode);
        configuration_hold_n = 1'b0;
        wait_low(8);
        loadMode = mode;
        wait_low(8);
        configuration_hold_n = 1'b1;
        wait_low(30);
    endtask : start_session
endmodule : scd_host_model
`default_nettype wire

/* File: tb_secure_config_decrypt_keyprog.sv */
// self-checking bench for the secure configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_secure_config_decrypt_keyprog;
    localparam logic [127:0] KEY_A = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] BAD_CIPHER = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] PLAIN_REF = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] BLK_BASE = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    logic clk;
    logic rst;
    logic porRst;
    logic ce;
    logic dataClk;
    logic [7:0] dataIn;
    logic [2:0] loadMode;
    logic configuration_hold_n;
    logic keyProgTck;
    logic keyProgTdi;
    logic keyProgEnable;
    logic voltSelN;
    scd_pkg::scd_cell_type cellOut;
    scd_pkg::scd_status_type status;
    int failCount = 0;
    int nChecks = 0;
    int cycles = 0;
    int validSeen = 0;

    scd_config_decrypt i_scd_config_decrypt (.clk(clk), .rst(rst), .porRst(porRst), .ce(ce),
        .dataClk(dataClk), .dataIn(dataIn), .loadMode(loadMode),
        .configuration_hold_n(configuration_hold_n), .keyProgTck(keyProgTck),
        .keyProgTdi(keyProgTdi), .keyProgEnable(keyProgEnable), .cellOut(cellOut),
        .status(status));

    scd_host_model i_scd_host_model (.clk(clk), .dataClk(dataClk), .dataIn(dataIn),
        .loadMode(loadMode), .configuration_hold_n(configuration_hold_n),
        .keyProgTck(keyProgTck), .keyProgTdi(keyProgTdi), .keyProgEnable(keyProgEnable),
        .prog_voltage_select_n(voltSelN));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task testDone;
        $display("checks=%0d mismatches=%0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : testDone

    // generous ceiling: the whole sequence needs well under 10000 cycles
    always @(negedge clk)
    begin
        cycles++;
        if (cellOut.valid === 1'b1)
            validSeen++;
        if (cycles == 20000)
        begin
            failCount++;
            testDone();
        end
    end

    task check(input logic [127:0] got, input logic [127:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task check_status(input logic [3:0] exp);
        i_scd_host_model.wait_low(6);
        check({124'h0, status}, {124'h0, exp});
    endtask : check_status

    task t_plain_bypass;
        int b;
        i_scd_host_model.start_session(3'h3);
        validSeen = 0;
        i_scd_host_model.send_byte(scd_pkg::HDR_PLAIN);
        for (b = 0; b < 4; b++)
        begin
            i_scd_host_model.send_block(BLK_BASE + 128'(b));
            check(cellOut.data, BLK_BASE + 128'(b));
        end
        check_status(4'h1);
        check(128'(validSeen), 128'h4);
    endtask : t_plain_bypass

    task t_plain_bad_header;
        i_scd_host_model.start_session(3'h3);
        validSeen = 0;
        // frozen loader must not take the header at all
        ce = 1'b0;
        i_scd_host_model.send_byte(scd_pkg::HDR_ENC);
        check_status(4'h4);
        ce = 1'b1;
        i_scd_host_model.send_byte(scd_pkg::HDR_ENC);
        check_status(4'h2);
        check(128'(validSeen), 128'h0);
    endtask : t_plain_bad_header

    task t_key_program;
        i_scd_host_model.prog_key(KEY_A, 127);
        check_status(4'h0);
        i_scd_host_model.prog_key(KEY_A, 128);
        check_status(4'h8);
        check({127'h0, voltSelN}, 128'h1);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        // ordinary reset must leave the fuse alone
        check_status(4'h8);
    endtask : t_key_program

    task t_keyed_plain;
        i_scd_host_model.start_session(3'h0);
        validSeen = 0;
        i_scd_host_model.send_byte(scd_pkg::HDR_PLAIN);
        check_status(4'hA);
        check(128'(validSeen), 128'h0);
    endtask : t_keyed_plain

    task t_keyed_modes;
        int m;
        logic gated;
        for (m = 0; m < 6; m++)
        begin
            gated = (m == 1) || (m == 4) || (m == 5);
            i_scd_host_model.start_session(m[2:0]);
            validSeen = 0;
            i_scd_host_model.send_byte(scd_pkg::HDR_ENC);
            check_status(gated ? 4'hA : 4'hC);
            if (!gated)
            begin
                // standard test block: its plaintext lacks the check word, as a foreign key's
                i_scd_host_model.send_block(BAD_CIPHER);
                check_status(4'hA);
                check(cellOut.data, PLAIN_REF);
                check(128'(validSeen), 128'h0);
            end
        end
    endtask : t_keyed_modes

    initial
    begin
        rst = 1'b1;
        porRst = 1'b1;
        ce = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        porRst = 1'b0;
        check_status(4'h0);
        check({127'h0, cellOut.valid}, 128'h0);
        t_plain_bypass();
        t_plain_bad_header();
        t_key_program();
        t_keyed_plain();
        t_keyed_modes();
        testDone();
    end
endmodule : tb_secure_config_decrypt_keyprog
`default_nettype wire
